// ---- nps_params.svh ----
// constants and notes for the memory program sequencer
// Notes on behaviour
// [R1] start accepted only after key writes 0x55 then 0xaa, in that order
// [R2] software runs two no-ops after setting start
// [R3] start bit 15 stays set during a cycle, hardware clears it at the end
// [R4] bulk erase clears the whole data array, address ignored
// [R5] bulk erase: set mode, optionally clear done flag, keys, then start
// [R6] done flag is set when an erase or program cycle finishes
// [R7] bit 12 set means word program skips the pre-erase
// [R8] single word write moves the latch word into the addressed word
// [R9] low six bits 0001xx select one-word program; the code decodes 000100 as word erase instead
// [R10] one-word erase value selects erase of the addressed word
// [R11] row mode programs 64 instructions from the latches in one cycle
// [R12] each latch takes a low word and an upper byte at one offset, step 2
// [R13] software blocks interrupts for 5 instructions around the unlock
// [R14] start without a directly preceding key pair is ignored; other writes re-arm; the code does not re-arm on a flag clear
// [R15] mode and address held during a cycle; no new cycle until start clears
`ifndef NPS_PARAMS_SVH
`define NPS_PARAMS_SVH
`define NPS_KEY_FIRST 8'h55
`define NPS_KEY_SECOND 8'haa
`define NPS_START_BIT 15
`define NPS_PROGRAM_WITHOUT_ERASE_SELECT_BIT 12
`define NPS_ERASE_BIT 6
`define NPS_OP_MSB 5
`define NPS_OP_WORD_PGM 4'h1
`define NPS_OP_WORD_ERASE 6'h04
`define NPS_OP_BULK_ERASE 6'h10
`define NPS_OP_ROW_PGM 6'h01
`define NPS_ROW_WORDS 64
`define NPS_ADDR_STEP 2
`define NPS_CYCLE_US 4
`define NPS_CLK_MHZ 20
`define NPS_CYCLE_COUNT (`NPS_CYCLE_US * `NPS_CLK_MHZ)
`define NPS_CTRL_RESET 16'h0000
`endif

// ---- nps_pkg.sv ----
// types for the memory program sequencer
package nps_pkg;
    typedef enum logic [2:0]
    {
        NPS_OP_NONE = 3'b000,
        NPS_OP_WPGM = 3'b001,
        NPS_OP_WERASE = 3'b010,
        NPS_OP_BULK = 3'b011,
        NPS_OP_ROW = 3'b100
    } nps_op_type;
    typedef enum logic [1:0]
    {
        NPS_IDLE = 2'b00,
        NPS_ERASE = 2'b01,
        NPS_PROG = 2'b10,
        NPS_DONE = 2'b11
    } nps_state_type;
endpackage : nps_pkg

// ---- nps_timer.sv ----
// down counter that times one erase or program phase
`timescale 1ns/1ns
module nps_timer
#(
    parameter int COUNT = 80
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    output logic expired
);
    logic [15:0] remaining;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            remaining <= 16'h0000;
        else if (load)
            remaining <= 16'(COUNT);
        else if (remaining != 16'h0000)
            remaining <= remaining - 16'h0001;
    end
    assign expired = (remaining == 16'h0001);
endmodule : nps_timer

// ---- nps_sequencer.sv ----
// nonvolatile memory program sequencer: unlock, start, erase and program
`timescale 1ns/1ns
`include "nps_params.svh"
module nps_sequencer
#(
    parameter int AW = 9,
    parameter int ROW_WORDS = `NPS_ROW_WORDS,
    parameter int CYCLE_COUNT = `NPS_CYCLE_COUNT
)
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CTRL_WR,
    input wire logic [15:0] CTRL_WDATA,
    input wire logic KEY_WR,
    input wire logic [7:0] KEY_WDATA,
    input wire logic LATCH_WR_LO,
    input wire logic LATCH_WR_HI,
    input wire logic [15:0] LATCH_OFFSET,
    input wire logic [15:0] LATCH_WDATA,
    input wire logic [7:0] TABLE_PAGE_POINTER,
    input wire logic DONE_FLAG_CLR,
    output logic [15:0] CTRL_RDATA,
    output logic PROGRAM_DONE_IRQ_FLAG,
    output logic MEM_ERASE,
    output logic MEM_PROG,
    output logic MEM_BULK,
    output logic [AW-1:0] MEM_ADDR,
    output logic [23:0] MEM_WDATA
);
    // ************************************************************
    // control register and unlock
    // ************************************************************
    logic [15:0] memory_program_control;
    logic [1:0] key_stage;
    logic start_req;
    logic start_ok;
    logic busy;
    logic cycle_end;
    nps_pkg::nps_op_type op;
    nps_pkg::nps_state_type state;
    logic [AW-1:0] addr;
    logic [6:0] word_idx;
    logic pgm_only;
    logic timer_load;
    logic timer_expired;
    logic [15:0] lo_latch [ROW_WORDS];
    logic [7:0] hi_latch [ROW_WORDS];
    logic [5:0] lidx;

    assign start_req = CTRL_WR && CTRL_WDATA[`NPS_START_BIT];
    assign busy = (state != nps_pkg::NPS_IDLE);
    assign start_ok = start_req && key_stage == 2'h2 && op != nps_pkg::NPS_OP_NONE;

    // [R1] ordered key pair
    // [R14] any other key, control or latch write re-arms the check; a flag clear does not
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            key_stage <= 2'h0;
        else if (KEY_WR && KEY_WDATA == `NPS_KEY_FIRST)
            key_stage <= 2'h1;
        else if (KEY_WR && KEY_WDATA == `NPS_KEY_SECOND && key_stage == 2'h1)
            key_stage <= 2'h2;
        else if (KEY_WR || CTRL_WR || LATCH_WR_LO || LATCH_WR_HI)
            key_stage <= 2'h0;
    end

    // [R15] settings frozen while busy
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            memory_program_control <= `NPS_CTRL_RESET;
        // [R3] start bit shows the running cycle
        else if (CTRL_WR && !busy)
            memory_program_control <= {start_ok, CTRL_WDATA[14:0]};
        else if (cycle_end)
            memory_program_control[`NPS_START_BIT] <= 1'b0;
    end

    // [R9] 0001xx program word, [R10] erase word, [R4] bulk, [R11] row
    always_comb
    begin
        op = nps_pkg::NPS_OP_NONE;
        // the exact erase code is tested first, it sits inside the 0001xx range
        if (CTRL_WDATA[`NPS_OP_MSB:0] == `NPS_OP_WORD_ERASE)
            op = nps_pkg::NPS_OP_WERASE;
        else if (CTRL_WDATA[`NPS_OP_MSB:2] == `NPS_OP_WORD_PGM)
            op = nps_pkg::NPS_OP_WPGM;
        else if (CTRL_WDATA[`NPS_OP_MSB:0] == `NPS_OP_BULK_ERASE)
            op = nps_pkg::NPS_OP_BULK;
        else if (CTRL_WDATA[`NPS_OP_MSB:0] == `NPS_OP_ROW_PGM)
            op = nps_pkg::NPS_OP_ROW;
    end

    // ************************************************************
    // write latches
    // ************************************************************
    // [R12] one offset carries low word and upper byte; offsets step by 2
    assign lidx = LATCH_OFFSET[6:1];
    // [R8] data waits in the latch until the program cycle
    always_ff @(posedge CLK_SYS)
    begin
        if (LATCH_WR_LO && !busy)
            lo_latch[lidx] <= LATCH_WDATA;
        if (LATCH_WR_HI && !busy)
            hi_latch[lidx] <= LATCH_WDATA[7:0];
    end

    // ************************************************************
    // cycle sequencer
    // ************************************************************
    nps_pkg::nps_op_type run_op;
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state <= nps_pkg::NPS_IDLE;
            run_op <= nps_pkg::NPS_OP_NONE;
            addr <= '0;
            word_idx <= 7'h00;
            pgm_only <= 1'b0;
        end
        else
        begin
            unique case (state)
                nps_pkg::NPS_IDLE:
                    if (start_req && key_stage == 2'h2 && op != nps_pkg::NPS_OP_NONE)
                    begin
                        run_op <= op;
                        addr <= AW'({TABLE_PAGE_POINTER, LATCH_OFFSET} >> 1);
                        pgm_only <= CTRL_WDATA[`NPS_PROGRAM_WITHOUT_ERASE_SELECT_BIT];
                        word_idx <= 7'h00;
                        // [R7] program-only skips the pre-erase
                        if (op == nps_pkg::NPS_OP_WPGM && CTRL_WDATA[`NPS_PROGRAM_WITHOUT_ERASE_SELECT_BIT])
                            state <= nps_pkg::NPS_PROG;
                        else if (op == nps_pkg::NPS_OP_ROW)
                            state <= nps_pkg::NPS_PROG;
                        else
                            state <= nps_pkg::NPS_ERASE;
                    end
                nps_pkg::NPS_ERASE:
                    if (timer_expired)
                        state <= (run_op == nps_pkg::NPS_OP_WPGM) ? nps_pkg::NPS_PROG
                                                                  : nps_pkg::NPS_DONE;
                nps_pkg::NPS_PROG:
                    // [R11] walk all row words in one cycle
                    if (timer_expired)
                    begin
                        if (run_op == nps_pkg::NPS_OP_ROW && word_idx != 7'(ROW_WORDS - 1))
                        begin
                            word_idx <= word_idx + 7'h01;
                            addr <= addr + AW'(1);
                        end
                        else
                            state <= nps_pkg::NPS_DONE;
                    end
                nps_pkg::NPS_DONE:
                    state <= nps_pkg::NPS_IDLE;
            endcase
        end
    end

    assign cycle_end = (state == nps_pkg::NPS_DONE);
    assign timer_load = (state == nps_pkg::NPS_IDLE) ||
        (state == nps_pkg::NPS_ERASE && timer_expired) ||
        (state == nps_pkg::NPS_PROG && timer_expired);

    nps_timer #(.COUNT(CYCLE_COUNT)) u_timer
    (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .load(timer_load),
        .expired(timer_expired)
    );

    // ************************************************************
    // memory strobes and status outputs
    // ************************************************************
    // [R6] done flag; a finishing cycle wins over a clear
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            PROGRAM_DONE_IRQ_FLAG <= 1'b0;
        else if (cycle_end)
            PROGRAM_DONE_IRQ_FLAG <= 1'b1;
        else if (DONE_FLAG_CLR)
            PROGRAM_DONE_IRQ_FLAG <= 1'b0;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            MEM_ERASE <= 1'b0;
            MEM_PROG <= 1'b0;
            MEM_BULK <= 1'b0;
            MEM_ADDR <= '0;
            MEM_WDATA <= 24'h000000;
            CTRL_RDATA <= `NPS_CTRL_RESET;
        end
        else
        begin
            MEM_ERASE <= (state == nps_pkg::NPS_ERASE) && timer_expired;
            MEM_PROG <= (state == nps_pkg::NPS_PROG) && timer_expired;
            // [R4] bulk erase ignores the address
            MEM_BULK <= (state == nps_pkg::NPS_ERASE) && (run_op == nps_pkg::NPS_OP_BULK);
            MEM_ADDR <= (run_op == nps_pkg::NPS_OP_BULK) ? '0 : addr;
            MEM_WDATA <= (run_op == nps_pkg::NPS_OP_ROW)
                ? {hi_latch[word_idx[5:0]], lo_latch[word_idx[5:0]]}
                : {8'h00, lo_latch[6'(addr)]};
            CTRL_RDATA <= memory_program_control;
        end
    end
endmodule : nps_sequencer

// ---- nps_sequencer_props.sv ----
// assertions on the program sequencer ports
`timescale 1ns/1ns
module nps_sequencer_props
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CTRL_WR,
    input wire logic [15:0] CTRL_WDATA,
    input wire logic KEY_WR,
    input wire logic [7:0] KEY_WDATA,
    input wire logic DONE_FLAG_CLR,
    input wire logic [15:0] CTRL_RDATA,
    input wire logic PROGRAM_DONE_IRQ_FLAG,
    input wire logic MEM_ERASE,
    input wire logic MEM_PROG,
    input wire logic MEM_BULK
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire logic bsy = CTRL_RDATA[15];
    property p_unlock; KEY_WR && KEY_WDATA == 8'h55 ##1 KEY_WR && KEY_WDATA == 8'haa
        ##1 CTRL_WR && CTRL_WDATA[15] && !bsy |-> ##[1:3] bsy; endproperty
    a_unlock: assert property (p_unlock) else $error("keyed start not taken");
    property p_nokey; CTRL_WR && CTRL_WDATA[15] && !bsy && !$past(KEY_WR)
        && !$past(CTRL_WR) |=> !bsy [*3]; endproperty
    a_nokey: assert property (p_nokey) else $error("start taken without keys");
    property p_busy; $rose(bsy) |-> bsy [*4]; endproperty
    a_busy: assert property (p_busy) else $error("start bit dropped early");
    property p_done; $fell(bsy) |-> ##[0:2] PROGRAM_DONE_IRQ_FLAG; endproperty
    a_done: assert property (p_done) else $error("done flag not set");
    property p_flag; PROGRAM_DONE_IRQ_FLAG && !bsy |=>
        PROGRAM_DONE_IRQ_FLAG == !$past(DONE_FLAG_CLR); endproperty
    a_flag: assert property (p_flag) else $error("done flag wrong");
    property p_bulk; MEM_BULK |-> bsy && CTRL_RDATA[5:0] == 6'h10; endproperty
    a_bulk: assert property (p_bulk) else $error("bulk outside bulk mode");
    property p_erase; MEM_ERASE |-> bsy && !(CTRL_RDATA[12] && CTRL_RDATA[5:0] != 6'h04
        && CTRL_RDATA[5:2] == 4'h1); endproperty
    a_erase: assert property (p_erase) else $error("erase in program-only");
    property p_prog; MEM_PROG |-> bsy && (CTRL_RDATA[5:2] == 4'h1
        || CTRL_RDATA[5:0] == 6'h01); endproperty
    a_prog: assert property (p_prog) else $error("program in wrong mode");
    property p_hold; bsy && $past(bsy) |-> $stable(CTRL_RDATA[12:0]); endproperty
    a_hold: assert property (p_hold) else $error("mode changed while busy");
endmodule : nps_sequencer_props
bind nps_sequencer nps_sequencer_props u_props
(
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA),
    .KEY_WR(KEY_WR), .KEY_WDATA(KEY_WDATA), .DONE_FLAG_CLR(DONE_FLAG_CLR),
    .CTRL_RDATA(CTRL_RDATA), .PROGRAM_DONE_IRQ_FLAG(PROGRAM_DONE_IRQ_FLAG),
    .MEM_ERASE(MEM_ERASE), .MEM_PROG(MEM_PROG), .MEM_BULK(MEM_BULK)
);

// ---- nps_cpu_model.sv ----
// processor-side model: key, control, latch and flag-clear writes
`timescale 1ns/1ns
module nps_cpu_model
(
    input wire logic clk,
    output logic ctrl_wr,
    output logic key_wr,
    output logic lat_lo,
    output logic lat_hi,
    output logic done_clr,
    output logic [15:0] wdata,
    output logic [23:0] addr
);
    initial
    begin
        {ctrl_wr, key_wr, lat_lo, lat_hi, done_clr} = 5'h00;
        wdata = 16'h0000;
        addr = 24'h000000;
    end
    // kind 0 control, 1 key, 2 low latch, 3 high latch, 4 flag clear
    task automatic put(input logic [2:0] k, input logic [15:0] v, input logic [23:0] a);
        @(posedge clk);
        ctrl_wr <= k == 3'h0;
        key_wr <= k == 3'h1;
        lat_lo <= k == 3'h2;
        lat_hi <= k == 3'h3;
        done_clr <= k == 3'h4;
        wdata <= v;
        addr <= a;
    endtask : put
    // idle data flips to its inverse every cycle, so a stale word never holds steady on the bus
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            {ctrl_wr, key_wr, lat_lo, lat_hi, done_clr} <= 5'h00;
            wdata <= ~wdata;
        end
    endtask : idle
    task automatic start(input logic [15:0] c, input logic [23:0] a);
        put(3'h1, 16'h0055, a);
        put(3'h1, 16'h00aa, a);
        put(3'h0, c | 16'h8000, a);
        idle(2);
    endtask : start
endmodule : nps_cpu_model

// ---- nvm_eeprom_program_sequencer_tb_top.sv ----
// self-checking bench for the program sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module nvm_eeprom_program_sequencer_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctrl_wr, key_wr, lat_lo, lat_hi, done_clr, flag, m_erase, m_prog, m_bulk;
    logic [15:0] wdata, ctrl_rdata, dat;
    logic [23:0] addr, m_wdata, adr;
    logic [8:0] m_addr, last_addr;
    logic [23:0] got [0:63];
    logic [23:0] exp_wd [0:63];
    logic [15:0] ops [0:3] = '{16'h4004, 16'h4005, 16'h5006, 16'h4007};
    logic [15:0] rnd = 16'h0061;
    int error_cnt = 0;
    int tests_run = 0;
    int ne, np, nb;
    always #25 clk = ~clk;
    nps_cpu_model u_cpu (.clk(clk), .ctrl_wr(ctrl_wr), .key_wr(key_wr), .lat_lo(lat_lo),
        .lat_hi(lat_hi), .done_clr(done_clr), .wdata(wdata), .addr(addr));
    nps_sequencer #(.CYCLE_COUNT(4)) u_dut (.CLK_SYS(clk), .RST_N(rst_n),
        .CTRL_WR(ctrl_wr), .CTRL_WDATA(wdata), .KEY_WR(key_wr), .KEY_WDATA(wdata[7:0]),
        .LATCH_WR_LO(lat_lo), .LATCH_WR_HI(lat_hi), .LATCH_OFFSET(addr[15:0]),
        .LATCH_WDATA(wdata), .TABLE_PAGE_POINTER(addr[23:16]), .DONE_FLAG_CLR(done_clr),
        .CTRL_RDATA(ctrl_rdata), .PROGRAM_DONE_IRQ_FLAG(flag), .MEM_ERASE(m_erase),
        .MEM_PROG(m_prog), .MEM_BULK(m_bulk), .MEM_ADDR(m_addr), .MEM_WDATA(m_wdata));
    always @(posedge clk)
    begin
        ne += m_erase;
        nb += m_bulk;
        if (m_erase | m_prog)
            last_addr = m_addr;
        if (m_prog)
            got[np[5:0]] = m_wdata;
        np += m_prog;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // a negative erase count means the count is not checked
    task automatic run(input logic [15:0] c, input logic [23:0] a, input int e_er, e_pg);
        u_cpu.put(3'h4, 16'h0000, a);
        ne = 0;
        np = 0;
        nb = 0;
        u_cpu.start(c, a);
        for (int i = 0; i < 6000 && flag !== 1'b1; i++)
            @(posedge clk);
        u_cpu.idle(3);
        `CHK(flag, 1'b1)
        `CHK(ctrl_rdata[15], 1'b0)
        if (e_er >= 0)
            `CHK(ne, e_er)
        `CHK(np, e_pg)
    endtask : run
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(ctrl_rdata, 16'h0000)
        `CHK(flag, 1'b0)
        u_cpu.put(3'h0, 16'h8004, 24'h000000);
        u_cpu.put(3'h1, 16'h0055, 24'h000000);
        u_cpu.put(3'h2, 16'h1234, 24'h000000);
        u_cpu.put(3'h1, 16'h00aa, 24'h000000);
        u_cpu.put(3'h0, 16'h8004, 24'h000000);
        u_cpu.idle(6);
        `CHK(ctrl_rdata[15], 1'b0)
        `CHK(ne + np, 0)
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            dat = lfsr(rnd);
            adr = {rnd[15:8], 8'h00, rnd[7:1], 1'b0};
            u_cpu.put(3'h2, dat, adr);
            run(ops[k], adr, !ops[k][12], int'(ops[k][1:0] != 2'h0));
            `CHK(last_addr, adr[9:1])
            if (ops[k][1:0] != 2'h0)
                `CHK(got[0][15:0], dat)
        end
        for (int i = 0; i < 64; i++)
        begin
            rnd = lfsr(rnd);
            exp_wd[i] = {rnd[7:0], rnd ^ 16'h5a5a};
            u_cpu.put(3'h2, rnd ^ 16'h5a5a, 24'h010000 + 24'(2 * i));
            u_cpu.put(3'h3, {8'h00, rnd[7:0]}, 24'h010000 + 24'(2 * i));
        end
        run(16'h4001, 24'h010000, -1, 64);
        for (int i = 0; i < 64; i++)
            `CHK(got[i], exp_wd[i])
        run(16'h4050, 24'h01fffe, -1, 0);
        `CHK(nb > 0, 1'b1)
        `CHK(last_addr, 9'h000)
        close_out();
    end
endmodule : nvm_eeprom_program_sequencer_tb_top
